// ---- pkg/sdc_regs.svh ----
/*
  Timing figures and mode-word field positions for the SDRAM controller.
  Assumes a single-data-rate SDRAM with a 64 ms / 4096-row refresh budget.
*/
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// ----------------------------------------------------------------------------
// Memory timing figures
// ----------------------------------------------------------------------------
`define SDC_T_REFI_NS 15625
`define SDC_T_RP_NS 20
`define SDC_T_RCD_NS 20
`define SDC_T_RFC_NS 70
`define SDC_T_WR_NS 15
`define SDC_T_XSR_NS 75
`define SDC_T_INIT_US 200
`define SDC_T_MRD_CYC 2
`define SDC_INIT_REF_CNT 2

// ----------------------------------------------------------------------------
// Mode word and address fields
// ----------------------------------------------------------------------------
`define SDC_MODE_CL_POS 4
`define SDC_MODE_BL_VAL 3'h0
`define SDC_ALL_BANKS_BIT 10
`define SDC_BANK_COUNT 4

`endif

// ---- pkg/sdc_pkg.sv ----
/*
  Types shared by the SDRAM controller: memory commands and controller states.
  Assumes the command encoding {cs_n, ras_n, cas_n, we_n} of SDR SDRAM.
*/
package sdc_pkg;

  // --------------------------------------------------------------------------
  // Memory commands
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_NOP = 4'h7
  } sdc_cmd_t;

  // --------------------------------------------------------------------------
  // Controller states
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    S_INIT = 5'h00,
    S_INIT_PRE = 5'h01,
    S_INIT_REF = 5'h02,
    S_INIT_MRS = 5'h03,
    S_IDLE = 5'h04,
    S_ACT = 5'h05,
    S_RD = 5'h06,
    S_WR = 5'h07,
    S_RD_CAP = 5'h08,
    S_RD_OUT = 5'h09,
    S_DONE = 5'h0a,
    S_PRE = 5'h0b,
    S_PREALL = 5'h0c,
    S_REF = 5'h0d,
    S_SREF_IN = 5'h0e,
    S_SREF = 5'h0f,
    S_WAIT = 5'h10
  } sdc_state_t;

endpackage : sdc_pkg

// ---- rtl/sdc_bank_track.sv ----
/*
  Open-row tracker for one SDRAM bank: open flag, row held, and row hit.
  Assumes open and close are never asked in the same cycle.
*/
`timescale 1ns/100ps

module sdc_bank_track #(
  parameter int ROW_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic open_req,
  input wire logic close_req,
  input wire logic [ROW_W-1:0] row_in,
  // Status
  output logic is_open,
  output logic row_hit
);
  logic open_r, open_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;

  always_comb begin
    open_nxt = open_r;
    row_nxt = row_r;
    if (close_req) begin
      open_nxt = 1'b0;
    end else if (open_req) begin
      open_nxt = 1'b1;
      row_nxt = row_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open_r <= 1'b0;
      row_r <= '0;
    end else begin
      open_r <= open_nxt;
      row_r <= row_nxt;
    end
  end

  assign is_open = open_r;
  assign row_hit = open_r && (row_r == row_in);

endmodule : sdc_bank_track

// ---- rtl/sdc_top.sv ----
/*
  SDRAM controller with a 32-bit WISHBONE classic slave front end.
  Assumes the bus master holds CYC/STB/WE/SEL/ADR/DAT steady until ACK or ERR,
  and that the memory clock is the bus clock, supplied outside this block.
*/
// Summary of operation
// (R1) After the configured number of idle cycles the memory is put into self-refresh.
// (R2) With the per-bank option one row stays open in every bank, otherwise only one row in all.
// (R3) The CAS latency parameter is written to the mode word and times the read capture.
// (R4) Every memory interval except the fixed mode-register delay is derived from the bus clock frequency parameter in kHz.
// (R5) An optional pipelined read mode returns data one cycle earlier.
// (R6) Bus byte addresses map to column, bank and row of a parameterised array.
// (R7) A parameterised number of clock-enable outputs all follow the same level.
// (R8) Bus data and address are fixed at 32 bits.
// (R9) Each accepted bus cycle gets exactly one acknowledge after its data is settled.
// (R10) Periodic auto-refresh is issued and bus requests wait while it runs.
`timescale 1ns/100ps
`include "sdc_regs.svh"

module sdc_top #(
  parameter int BUS_CLOCK_KHZ = 50000,
  parameter bit PIPE_EN = 1'b0,
  parameter int IDLE_NOP_LIMIT = 1000,
  parameter bit PER_BANK_OPEN_ROWS = 1'b0,
  parameter int CAS_LATENCY = 3,
  parameter int ARRAY_ROW_COUNT = 4096,
  parameter int ARRAY_COLUMN_COUNT = 256,
  parameter int RAM_ADDR_WIDTH = 12,
  parameter int CLOCK_ENABLE_OUTPUT_COUNT = 1,
  parameter int INIT_WAIT_CYCLES = (`SDC_T_INIT_US * BUS_CLOCK_KHZ + 999) / 1000
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Bus slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_ADR,
  input wire logic [31:0] WB_DAT_WR,
  output logic [31:0] WB_DAT_RD,
  output logic WB_ACK,
  output logic WB_ERR,
  // Memory command pins
  output logic [CLOCK_ENABLE_OUTPUT_COUNT-1:0] SD_CKE,
  output logic SD_CS_N,
  output logic SD_RAS_N,
  output logic SD_CAS_N,
  output logic SD_WE_N,
  output logic [1:0] SD_BA,
  output logic [RAM_ADDR_WIDTH-1:0] MEMORY_ADDRESS_OUT,
  output logic [3:0] SD_DQM,
  // Memory data pins
  output logic [31:0] MEMORY_DATA_BIDIR_DRIVE,
  output logic MEMORY_DATA_BIDIR_EN,
  input wire logic [31:0] MEMORY_DATA_BIDIR_SENSE
);
  import sdc_pkg::*;

  // --------------------------------------------------------------------------
  // Derived geometry and timing
  // --------------------------------------------------------------------------
  localparam int COL_W = $clog2(ARRAY_COLUMN_COUNT);
  localparam int ROW_W = $clog2(ARRAY_ROW_COUNT);
  localparam int BANK_LO = 2 + COL_W;
  localparam int ROW_LO = BANK_LO + 2;
  localparam int TOP_LO = ROW_LO + ROW_W;
  localparam int TMR_W = 24;
  localparam int IDW = $clog2(IDLE_NOP_LIMIT) + 1;

  // Least times round up to whole cycles, never below one.
  function automatic int cyc_up(input longint ns);
    longint c;
    c = (ns * BUS_CLOCK_KHZ + 64'd999999) / 64'd1000000;
    return (c < 1) ? 1 : int'(c);
  endfunction : cyc_up

  localparam int RP_CYC = cyc_up(`SDC_T_RP_NS); // R4
  localparam int RCD_CYC = cyc_up(`SDC_T_RCD_NS); // R4
  localparam int RFC_CYC = cyc_up(`SDC_T_RFC_NS); // R4
  localparam int WR_CYC = cyc_up(`SDC_T_WR_NS); // R4
  localparam int XSR_CYC = cyc_up(`SDC_T_XSR_NS); // R4
  // The refresh interval is a longest time, so it rounds down.
  localparam int REFI_CYC = int'((64'd`SDC_T_REFI_NS * BUS_CLOCK_KHZ) / 64'd1000000); // R4
  localparam int RD_ACK_DLY = CAS_LATENCY + (PIPE_EN ? 1 : 2);
  localparam int WR_ACK_DLY = WR_CYC + 1;

  // --------------------------------------------------------------------------
  // Address split
  // --------------------------------------------------------------------------
  logic req;
  logic out_of_range;
  logic [COL_W-1:0] tgt_col;
  logic [1:0] tgt_ba;
  logic [ROW_W-1:0] tgt_row;

  assign req = WB_CYC && WB_STB; // R8
  assign tgt_col = WB_ADR[BANK_LO-1:2]; // R6
  assign tgt_ba = WB_ADR[ROW_LO-1:BANK_LO]; // R6
  assign tgt_row = WB_ADR[TOP_LO-1:ROW_LO]; // R6
  assign out_of_range = |WB_ADR[31:TOP_LO]; // R6

  // --------------------------------------------------------------------------
  // Open-row trackers
  // --------------------------------------------------------------------------
  logic [`SDC_BANK_COUNT-1:0] tr_open_req, tr_close_req, tr_open, tr_hit;

  genvar gi;
  generate
    for (gi = 0; gi < `SDC_BANK_COUNT; gi++) begin : g_bank
      sdc_bank_track #(.ROW_W(ROW_W)) u_track (
        .clk(CLOCK),
        .rst_n(RST_N),
        .open_req(tr_open_req[gi]),
        .close_req(tr_close_req[gi]),
        .row_in(tgt_row),
        .is_open(tr_open[gi]),
        .row_hit(tr_hit[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------------
  sdc_state_t state_r, state_nxt, ret_r, ret_nxt;
  sdc_cmd_t cmd_r, cmd_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic [15:0] ref_cnt_r, ref_cnt_nxt;
  logic ref_pend_r, ref_pend_nxt;
  logic [IDW-1:0] idle_cnt_r, idle_cnt_nxt;
  logic [1:0] init_cnt_r, init_cnt_nxt;
  logic sref_sel_r, sref_sel_nxt;
  logic cke_r, cke_nxt;
  logic [1:0] ba_r, ba_nxt;
  logic [RAM_ADDR_WIDTH-1:0] addr_r, addr_nxt;
  logic [3:0] dqm_r, dqm_nxt;
  logic [31:0] dq_o_r, dq_o_nxt, cap_r, cap_nxt, dat_r, dat_nxt;
  logic dq_oe_r, dq_oe_nxt, ack_r, ack_nxt, err_r, err_nxt;
  logic ref_tick, ref_issue;

  always_comb begin
    state_nxt = state_r;
    ret_nxt = ret_r;
    cmd_nxt = CMD_NOP;
    tmr_nxt = tmr_r;
    idle_cnt_nxt = '0;
    init_cnt_nxt = init_cnt_r;
    sref_sel_nxt = sref_sel_r;
    cke_nxt = cke_r;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    dqm_nxt = 4'hf;
    dq_o_nxt = dq_o_r;
    dq_oe_nxt = 1'b0;
    cap_nxt = cap_r;
    dat_nxt = dat_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    ref_issue = 1'b0;
    tr_open_req = '0;
    tr_close_req = '0;
    // Refresh interval counter runs in every state.
    ref_tick = (ref_cnt_r == 16'h0000);
    ref_cnt_nxt = ref_tick ? 16'(REFI_CYC - 1) : ref_cnt_r - 16'h0001; // R10
    case (state_r)
      S_INIT: begin
        if (tmr_r == '0) begin
          state_nxt = S_INIT_PRE;
        end else begin
          tmr_nxt = tmr_r - TMR_W'(1);
        end
      end
      S_INIT_PRE: begin
        cmd_nxt = CMD_PRE;
        addr_nxt = '0;
        addr_nxt[`SDC_ALL_BANKS_BIT] = 1'b1;
        tr_close_req = '1;
        tmr_nxt = TMR_W'(RP_CYC - 1);
        ret_nxt = S_INIT_REF;
        state_nxt = S_WAIT;
      end
      S_INIT_REF: begin
        cmd_nxt = CMD_REF;
        ref_issue = 1'b1;
        init_cnt_nxt = init_cnt_r + 2'h1;
        tmr_nxt = TMR_W'(RFC_CYC - 1);
        ret_nxt = (init_cnt_r == 2'(`SDC_INIT_REF_CNT - 1)) ? S_INIT_MRS : S_INIT_REF;
        state_nxt = S_WAIT;
      end
      S_INIT_MRS: begin
        cmd_nxt = CMD_MRS;
        ba_nxt = 2'h0;
        addr_nxt = '0;
        addr_nxt[`SDC_MODE_CL_POS +: 3] = 3'(CAS_LATENCY); // R3
        addr_nxt[2:0] = `SDC_MODE_BL_VAL;
        tmr_nxt = TMR_W'(`SDC_T_MRD_CYC - 1);
        ret_nxt = S_IDLE;
        state_nxt = S_WAIT;
      end
      S_IDLE: begin
        if (ack_r || err_r) begin
          // The master needs this cycle to drop or change its strobe.
          idle_cnt_nxt = '0;
        end else if (ref_pend_r) begin
          sref_sel_nxt = 1'b0;
          state_nxt = S_PREALL; // R10
        end else if (req && out_of_range) begin
          err_nxt = 1'b1; // R6
        end else if (req) begin
          ba_nxt = tgt_ba;
          if (tr_hit[tgt_ba]) begin
            state_nxt = WB_WE ? S_WR : S_RD;
          end else if (PER_BANK_OPEN_ROWS ? tr_open[tgt_ba] : |tr_open) begin // R2
            state_nxt = S_PRE;
          end else begin
            state_nxt = S_ACT;
          end
        end else if (idle_cnt_r == IDW'(IDLE_NOP_LIMIT - 1)) begin
          sref_sel_nxt = 1'b1;
          state_nxt = S_PREALL; // R1
        end else begin
          idle_cnt_nxt = idle_cnt_r + IDW'(1); // R1
        end
      end
      S_PRE: begin
        cmd_nxt = CMD_PRE;
        addr_nxt = '0;
        if (PER_BANK_OPEN_ROWS) begin
          tr_close_req[tgt_ba] = 1'b1; // R2
        end else begin
          addr_nxt[`SDC_ALL_BANKS_BIT] = 1'b1;
          tr_close_req = '1; // R2
        end
        tmr_nxt = TMR_W'(RP_CYC - 1);
        ret_nxt = S_ACT;
        state_nxt = S_WAIT;
      end
      S_ACT: begin
        cmd_nxt = CMD_ACT;
        addr_nxt = RAM_ADDR_WIDTH'(tgt_row); // R6
        tr_open_req[tgt_ba] = 1'b1;
        tmr_nxt = TMR_W'(RCD_CYC - 1);
        ret_nxt = WB_WE ? S_WR : S_RD;
        state_nxt = S_WAIT;
      end
      S_RD: begin
        cmd_nxt = CMD_RD;
        addr_nxt = RAM_ADDR_WIDTH'(tgt_col); // R6
        dqm_nxt = 4'h0;
        tmr_nxt = TMR_W'(CAS_LATENCY - 1); // R3
        ret_nxt = S_RD_CAP;
        state_nxt = S_WAIT;
      end
      S_RD_CAP: begin
        if (PIPE_EN) begin
          dat_nxt = MEMORY_DATA_BIDIR_SENSE; // R5
          ack_nxt = 1'b1; // R9
          state_nxt = S_IDLE;
        end else begin
          cap_nxt = MEMORY_DATA_BIDIR_SENSE; // R3
          state_nxt = S_RD_OUT;
        end
      end
      S_RD_OUT: begin
        dat_nxt = cap_r;
        ack_nxt = 1'b1; // R9
        state_nxt = S_IDLE;
      end
      S_WR: begin
        cmd_nxt = CMD_WR;
        addr_nxt = RAM_ADDR_WIDTH'(tgt_col);
        dqm_nxt = ~WB_SEL;
        dq_o_nxt = WB_DAT_WR;
        dq_oe_nxt = 1'b1;
        tmr_nxt = TMR_W'(WR_CYC - 1);
        ret_nxt = S_DONE;
        state_nxt = S_WAIT;
      end
      S_DONE: begin
        ack_nxt = 1'b1; // R9
        state_nxt = S_IDLE;
      end
      S_PREALL: begin
        cmd_nxt = CMD_PRE;
        addr_nxt = '0;
        addr_nxt[`SDC_ALL_BANKS_BIT] = 1'b1;
        tr_close_req = '1;
        tmr_nxt = TMR_W'(RP_CYC - 1);
        ret_nxt = sref_sel_r ? S_SREF_IN : S_REF;
        state_nxt = S_WAIT;
      end
      S_REF: begin
        cmd_nxt = CMD_REF;
        ref_issue = 1'b1; // R10
        tmr_nxt = TMR_W'(RFC_CYC - 1);
        ret_nxt = S_IDLE;
        state_nxt = S_WAIT;
      end
      S_SREF_IN: begin
        cmd_nxt = CMD_REF;
        ref_issue = 1'b1;
        cke_nxt = 1'b0; // R1
        state_nxt = S_SREF;
      end
      S_SREF: begin
        ref_issue = 1'b1;
        if (req) begin
          cke_nxt = 1'b1;
          sref_sel_nxt = 1'b0;
          tmr_nxt = TMR_W'(XSR_CYC - 1);
          ret_nxt = S_IDLE;
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (tmr_r == '0) begin
          state_nxt = ret_r;
        end else begin
          tmr_nxt = tmr_r - TMR_W'(1);
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    // A tick in the issuing cycle wins over the clear.
    ref_pend_nxt = ref_tick || (ref_pend_r && !ref_issue); // R10
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= S_INIT;
      ret_r <= S_IDLE;
      cmd_r <= CMD_NOP;
      tmr_r <= TMR_W'(INIT_WAIT_CYCLES - 1);
      ref_cnt_r <= 16'(REFI_CYC - 1);
      ref_pend_r <= 1'b0;
      idle_cnt_r <= '0;
      init_cnt_r <= 2'h0;
      sref_sel_r <= 1'b0;
      cke_r <= 1'b1;
      ba_r <= 2'h0;
      addr_r <= '0;
      dqm_r <= 4'hf;
      dq_o_r <= 32'h0000_0000;
      dq_oe_r <= 1'b0;
      cap_r <= 32'h0000_0000;
      dat_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ret_r <= ret_nxt;
      cmd_r <= cmd_nxt;
      tmr_r <= tmr_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      ref_pend_r <= ref_pend_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      init_cnt_r <= init_cnt_nxt;
      sref_sel_r <= sref_sel_nxt;
      cke_r <= cke_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      dqm_r <= dqm_nxt;
      dq_o_r <= dq_o_nxt;
      dq_oe_r <= dq_oe_nxt;
      cap_r <= cap_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign SD_CKE = {CLOCK_ENABLE_OUTPUT_COUNT{cke_r}}; // R7
  assign {SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N} = cmd_r;
  assign SD_BA = ba_r;
  assign MEMORY_ADDRESS_OUT = addr_r;
  assign SD_DQM = dqm_r;
  assign MEMORY_DATA_BIDIR_DRIVE = dq_o_r;
  assign MEMORY_DATA_BIDIR_EN = dq_oe_r;
  assign WB_DAT_RD = dat_r;
  assign WB_ACK = ack_r;
  assign WB_ERR = err_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_rd_cmd;
    cmd_r == CMD_RD;
  endsequence

  sequence s_rd_done;
    ##RD_ACK_DLY ack_r;
  endsequence

  a_ack_one_pulse: assert property (@(posedge CLOCK) disable iff (!RST_N) // R9
    ack_r |=> !ack_r) else $error("acknowledge held longer than one cycle");
  a_rd_cas_ack: assert property (@(posedge CLOCK) disable iff (!RST_N) // R3
    s_rd_cmd |-> s_rd_done) else $error("read acknowledge off the CAS latency");
  a_wr_ack_delay: assert property (@(posedge CLOCK) disable iff (!RST_N) // R9
    (cmd_r == CMD_WR) |-> dq_oe_r ##WR_ACK_DLY ack_r) else $error("write not acknowledged in time");
  a_mode_cas_field: assert property (@(posedge CLOCK) disable iff (!RST_N) // R3
    (cmd_r == CMD_MRS) |-> addr_r[`SDC_MODE_CL_POS +: 3] == 3'(CAS_LATENCY)) else $error("mode word CAS wrong");
  a_single_open_row: assert property (@(posedge CLOCK) disable iff (!RST_N) // R2
    !PER_BANK_OPEN_ROWS |-> $onehot0(tr_open)) else $error("more than one row open");
  a_rw_row_open: assert property (@(posedge CLOCK) disable iff (!RST_N) // R2
    (cmd_r == CMD_RD || cmd_r == CMD_WR) |-> tr_open[ba_r]) else $error("access to a closed bank");
  a_sref_idle_entry: assert property (@(posedge CLOCK) disable iff (!RST_N) // R1
    (state_r == S_IDLE && !ack_r && !err_r && !ref_pend_r && !req && idle_cnt_r == IDW'(IDLE_NOP_LIMIT - 1))
    |=> state_r == S_PREALL ##1 cmd_r == CMD_PRE) else $error("self-refresh not entered at idle limit");
  a_cke_fall_cmd: assert property (@(posedge CLOCK) disable iff (!RST_N) // R1
    $fell(cke_r) |-> cmd_r == CMD_REF) else $error("clock enable dropped without refresh command");
  a_cke_uniform: assert property (@(posedge CLOCK) disable iff (!RST_N) // R7
    (SD_CKE == {CLOCK_ENABLE_OUTPUT_COUNT{cke_r}} && (cke_r || state_r == S_SREF)))
    else $error("clock enables disagree or low outside self-refresh");
  a_ref_priority: assert property (@(posedge CLOCK) disable iff (!RST_N) // R10
    (state_r == S_IDLE && ref_pend_r && !ack_r && !err_r) |=> state_r == S_PREALL ##1 !sref_sel_r)
    else $error("refresh not taken ahead of bus request");
  a_err_range: assert property (@(posedge CLOCK) disable iff (!RST_N) // R6
    err_r |-> $past(out_of_range) && !ack_r) else $error("error answer without a bad address");

endmodule : sdc_top

// ---- bench/sdc_mem_model.sv ----
/*
  Behavioural single-data-rate SDRAM array seen from the controller's pins.
  Assumes the memory shares the controller clock and the bench merges the data lines.
*/
`timescale 1ns/100ps

module sdc_mem_model #(
  parameter int CL = 3,
  parameter int AW = 12,
  parameter int CKE_N = 1,
  parameter bit PER_BANK_OPEN_ROWS = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins
  input wire logic [CKE_N-1:0] cke,
  input wire logic [3:0] cmd,
  input wire logic [1:0] ba,
  input wire logic [AW-1:0] addr,
  input wire logic [3:0] dqm,
  // Data pins
  input wire logic [31:0] dq_in,
  input wire logic dq_en,
  output logic [31:0] dq_out,
  // Observation
  output int proto_errs,
  output int act_count,
  output logic [1:0] last_bank,
  output logic [AW-1:0] last_col,
  output logic [AW-1:0] last_row
);
  import sdc_pkg::*;
  logic [31:0] mem [logic [AW+9:0]];
  logic [AW-1:0] row_r [4];
  logic [3:0] open_r;
  logic [31:0] pipe_d [CL];
  logic [CL-1:0] pipe_v;
  logic [31:0] noise_r;
  logic [AW+9:0] key;

  assign key = {ba, row_r[ba], addr[7:0]};
  // Outside the read hold window the lines wander, so a capture on the wrong edge is seen.
  assign dq_out = pipe_v[CL-1] ? pipe_d[CL-1] : noise_r;

  always @(posedge clk or negedge rst_n) begin : seq_blk
    logic [31:0] wd;
    if (!rst_n) begin
      open_r <= 4'h0;
      pipe_v <= '0;
      noise_r <= 32'h5a3c_0f96;
      proto_errs <= 0;
      act_count <= 0;
    end else begin
      noise_r <= noise_r + 32'h1357_9bdf;
      pipe_v <= {pipe_v[CL-2:0], 1'b0};
      for (int i = 1; i < CL; i++) begin
        pipe_d[i] <= pipe_d[i-1];
      end
      if (dq_en && cmd !== CMD_WR) begin
        proto_errs <= proto_errs + 1;
      end
      if (cke[0]) begin
        case (cmd)
          CMD_ACT: begin
            if (open_r[ba] || (!PER_BANK_OPEN_ROWS && open_r != 4'h0)) begin
              proto_errs <= proto_errs + 1;
            end
            open_r[ba] <= 1'b1;
            row_r[ba] <= addr;
            act_count <= act_count + 1;
          end
          CMD_PRE: begin
            if (addr[10]) begin
              open_r <= 4'h0;
            end else begin
              open_r[ba] <= 1'b0;
            end
          end
          CMD_REF: begin
            if (open_r != 4'h0) begin
              proto_errs <= proto_errs + 1;
            end
          end
          CMD_WR, CMD_RD: begin
            if (!open_r[ba] || (cmd === CMD_WR) !== dq_en) begin
              proto_errs <= proto_errs + 1;
            end
            last_bank <= ba;
            last_col <= addr;
            last_row <= row_r[ba];
            wd = mem.exists(key) ? mem[key] : noise_r;
            if (cmd === CMD_WR) begin
              for (int b = 0; b < 4; b++) begin
                if (!dqm[b]) begin
                  wd[8*b+:8] = dq_in[8*b+:8];
                end
              end
              mem[key] = wd;
            end else begin
              pipe_d[0] <= wd;
              pipe_v[0] <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule : sdc_mem_model

// ---- bench/sdc_top_tb.sv ----
/*
  Self-checking bench for the SDRAM controller: random and corner bus traffic against a memory model.
  Assumes the design files and the model are compiled before this file.
*/
`timescale 1ns/100ps

module sdc_top_tb;
  import sdc_pkg::*;
  localparam int KHZ = 20000;
  localparam int CL = 3;
  localparam int NOPS = 40;
  localparam int CKEN = 2;
  localparam int REFI = 15625 * KHZ / 1000000;
  logic CLOCK, RST_N, WB_CYC, WB_STB, WB_WE, WB_ACK, WB_ERR, SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N, DQ_EN;
  logic [3:0] WB_SEL, SD_DQM, cmd_now;
  logic [31:0] WB_ADR, WB_DAT_WR, WB_DAT_RD, DQ_DRIVE, DQ_SENSE, mdl_dq;
  logic [CKEN-1:0] SD_CKE;
  logic [1:0] SD_BA, mdl_bank;
  logic [11:0] MEMORY_ADDRESS_OUT, mdl_col, mdl_row;
  int errors, total_checks, acks, ops, gap, cycles, refs, proto_errs, act_count;
  logic init_done, slept, have_ref;
  logic [31:0] seed;
  logic [31:0] shadow [logic [31:0]];
  logic [31:0] used_q [$];

  assign cmd_now = {SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N};
  assign DQ_SENSE = DQ_EN ? DQ_DRIVE : mdl_dq;

  sdc_top #(.BUS_CLOCK_KHZ(KHZ), .IDLE_NOP_LIMIT(NOPS), .CAS_LATENCY(CL), .CLOCK_ENABLE_OUTPUT_COUNT(CKEN),
    .INIT_WAIT_CYCLES(20)) i_sdc_top (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC(WB_CYC), .WB_STB(WB_STB),
    .WB_WE(WB_WE), .WB_SEL(WB_SEL), .WB_ADR(WB_ADR), .WB_DAT_WR(WB_DAT_WR), .WB_DAT_RD(WB_DAT_RD),
    .WB_ACK(WB_ACK), .WB_ERR(WB_ERR), .SD_CKE(SD_CKE), .SD_CS_N(SD_CS_N), .SD_RAS_N(SD_RAS_N),
    .SD_CAS_N(SD_CAS_N), .SD_WE_N(SD_WE_N), .SD_BA(SD_BA), .MEMORY_ADDRESS_OUT(MEMORY_ADDRESS_OUT),
    .SD_DQM(SD_DQM), .MEMORY_DATA_BIDIR_DRIVE(DQ_DRIVE), .MEMORY_DATA_BIDIR_EN(DQ_EN),
    .MEMORY_DATA_BIDIR_SENSE(DQ_SENSE));

  sdc_mem_model #(.CL(CL), .AW(12), .CKE_N(CKEN), .PER_BANK_OPEN_ROWS(1'b0)) i_sdc_mem_model (.clk(CLOCK),
    .rst_n(RST_N), .cke(SD_CKE), .cmd(cmd_now), .ba(SD_BA), .addr(MEMORY_ADDRESS_OUT), .dqm(SD_DQM),
    .dq_in(DQ_DRIVE), .dq_en(DQ_EN), .dq_out(mdl_dq), .proto_errs(proto_errs), .act_count(act_count),
    .last_bank(mdl_bank), .last_col(mdl_col), .last_row(mdl_row));

  always #25 CLOCK = ~CLOCK;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : next_rand

  // One classic cycle; the request is held until the answering edge, then dropped there.
  task automatic wb_op(input logic we, input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                       output logic [31:0] rd, output logic err);
    int n;
    @(posedge CLOCK);
    WB_CYC <= 1'b1;
    WB_STB <= 1'b1;
    WB_WE <= we;
    WB_ADR <= adr;
    WB_DAT_WR <= dat;
    WB_SEL <= sel;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (WB_ACK !== 1'b1 && WB_ERR !== 1'b1 && n < 400);
    check("bus answer in time", n < 400, 1'b1);
    rd = WB_DAT_RD;
    err = WB_ERR;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
  endtask : wb_op

  task automatic access(input logic we, input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] rd;
    logic err;
    if (we && !shadow.exists(adr)) begin
      sel = 4'hf;
      used_q.push_back(adr);
    end
    wb_op(we, adr, dat, sel, rd, err);
    ops++;
    check("error flag", err, 1'b0);
    check("bank", mdl_bank, adr[11:10]);
    check("column", mdl_col, {4'h0, adr[9:2]});
    check("row", mdl_row, adr[23:12]);
    if (we) begin
      for (int b = 0; b < 4; b++) begin
        if (sel[b]) begin
          shadow[adr][8*b+:8] = dat[8*b+:8];
        end
      end
    end else begin
      check("read data", rd, shadow[adr]);
    end
  endtask : access

  always @(posedge CLOCK) begin
    cycles++;
    if (RST_N === 1'b1 && init_done) begin
      check("clock enable lanes", SD_CKE, {CKEN{SD_CKE[0]}});
      acks += (WB_ACK === 1'b1);
      slept = slept | (SD_CKE[0] !== 1'b1);
      gap++;
      if (cmd_now === CMD_REF && SD_CKE[0] === 1'b1) begin
        if (have_ref && !slept) begin
          check("refresh spacing", gap >= REFI - 30 && gap <= REFI + 40, 1'b1);
          refs++;
        end
        have_ref = 1'b1;
        slept = 1'b0;
        gap = 0;
      end
    end
    if (cycles >= 12000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    logic [31:0] rd, adr;
    logic err;
    int n, acts;
    logic [31:0] corner [3];
    corner = '{32'h0000_0000, 32'h00ff_fffc, 32'h0080_0000};
    {CLOCK, RST_N, WB_CYC, WB_STB, WB_WE, WB_SEL, WB_ADR, WB_DAT_WR} = '0;
    {errors, total_checks, acks, ops, gap, cycles, refs} = '0;
    {init_done, slept, have_ref} = '0;
    seed = 32'd92219;
    repeat (3) @(posedge CLOCK);
    check("clock enable in reset", SD_CKE, {CKEN{1'b1}});
    check("command in reset", cmd_now, CMD_NOP);
    check("ack in reset", WB_ACK, 1'b0);
    RST_N <= 1'b1;
    n = 0;
    while (cmd_now !== CMD_MRS && n < 300) begin
      @(posedge CLOCK);
      n++;
    end
    check("mode latency field", MEMORY_ADDRESS_OUT[6:4], CL);
    init_done = 1'b1;
    // Boundary rows, banks and columns, with row misses between them.
    foreach (corner[i]) begin
      access(1'b1, corner[i], 32'hc0de_0000 + i, 4'hf);
      access(1'b1, corner[i], 32'h1234_5678 ^ i, 4'b0101);
    end
    foreach (corner[i]) begin
      access(1'b0, corner[i], 32'h0, 4'h0);
    end
    acts = act_count;
    wb_op(1'b1, 32'h0100_0000, 32'hdead_beef, 4'hf, rd, err);
    check("range error", err, 1'b1);
    check("no access on error", act_count, acts);
    for (int i = 0; i < 170; i++) begin
      seed = next_rand(seed);
      adr = {8'h00, seed[23:12] & 12'h803, seed[11:2], 2'b00};
      if (seed[31] || used_q.size() == 0) begin
        access(1'b1, adr, next_rand(seed), seed[27:24]);
      end else begin
        access(1'b0, used_q[seed[30:24] % used_q.size()], 32'h0, 4'h0);
      end
      repeat (seed[29:28]) @(posedge CLOCK);
    end
    repeat (NOPS - 4) @(posedge CLOCK);
    check("awake before idle limit", SD_CKE, {CKEN{1'b1}});
    repeat (70) @(posedge CLOCK);
    check("self refresh entered", SD_CKE, {CKEN{1'b0}});
    access(1'b0, used_q[0], 32'h0, 4'h0);
    check("awake after access", SD_CKE, {CKEN{1'b1}});
    repeat (4) @(posedge CLOCK);
    check("one ack per cycle", acks, ops);
    check("memory protocol", proto_errs, 0);
    check("refreshes seen", refs >= 3, 1'b1);
    close_out();
  end
endmodule : sdc_top_tb
